// *** common/tile_status_pkg.sv ***
package tile_status_pkg;
  localparam int unsigned data_w = 32;
  localparam int unsigned reg_num_w = 8;
  // register numbers
  localparam logic [7:0] reg_boot_status = 8'h03;
  localparam logic [7:0] reg_security = 8'h05;
  localparam logic [7:0] reg_osc_control = 8'h06;
  localparam logic [7:0] reg_tile_cell_cnt = 8'h07;
  localparam logic [7:0] reg_tile_wire_cnt = 8'h08;
  localparam logic [7:0] reg_periph_cell_cnt = 8'h09;
  localparam logic [7:0] reg_periph_wire_cnt = 8'h0a;
  localparam logic [7:0] reg_ram_size = 8'h0c;
  localparam logic [7:0] reg_dbg_status = 8'h10;
  localparam logic [7:0] reg_dbg_pc = 8'h11;
  localparam logic [7:0] reg_dbg_sp = 8'h12;
  localparam logic [7:0] reg_fetch_core = 8'h13;
  localparam logic [7:0] reg_fetch_reg = 8'h14;
  // boot status fields
  localparam int unsigned boot_proc_lsb = 16;
  localparam int unsigned boot_override_bit = 8;
  localparam int unsigned boot_core_off_bit = 5;
  localparam int unsigned boot_skip_poll_bit = 4;
  localparam int unsigned boot_from_ram_bit = 3;
  localparam int unsigned boot_from_jtag_bit = 2;
  localparam int unsigned boot_pll_lsb = 0;
  // security fields
  localparam int unsigned sec_write_lock_bit = 31;
  localparam logic [31:0] sec_writable_mask = 32'h8000_5fb1;
  localparam int unsigned sec_global_dbg_off_bit = 14;
  localparam int unsigned sec_lock_all_bit = 12;
  localparam int unsigned sec_sector_lock_lsb = 8;
  localparam int unsigned sec_redundancy_bit = 7;
  localparam int unsigned sec_boot_override_bit = 5;
  localparam int unsigned sec_jtag_cfg_off_bit = 4;
  localparam int unsigned sec_jtag_tap_off_bit = 0;
  localparam int unsigned otp_sectors = 4;
  // oscillator control
  localparam int unsigned osc_core_en_bit = 1;
  localparam int unsigned osc_periph_en_bit = 0;
  localparam logic [1:0] osc_ctrl_reset = 2'h0;
  localparam int unsigned osc_cnt_w = 16;
  localparam int unsigned osc_count = 4;
  // debug capture fields, oscillator settle count, fetch operand widths, ram size
  localparam int unsigned dbg_status_w = 11;
  localparam logic [10:0] dbg_status_wmask = 11'h6df;
  localparam logic [10:0] dbg_status_cmask = 11'h7df;
  localparam int unsigned osc_settle_w = 3;
  localparam logic [2:0] osc_settle_cycles = 3'h4;
  localparam int unsigned fetch_core_w = 8;
  localparam int unsigned fetch_reg_w = 5;
  localparam int unsigned ram_size_lsb = 2;
  localparam logic [31:0] ram_size_default = 32'h0008_0000;
endpackage

// *** rtl/ring_osc_counter.sv ***
`timescale 1ns/100ps
// counter on an oscillator clock, counting while run is set; no reset so the count survives system reset
module ring_osc_counter #(
  parameter int unsigned width = 16
) (
  input wire logic osc_clk,
  input wire logic run,
  output logic [width-1:0] count_q
);
  logic run_meta_q;
  logic run_sync_q;
  // power-up value only; system reset leaves the count alone
  logic [width-1:0] cnt_q = '0;

  // run enable crosses into the oscillator domain
  always_ff @(posedge osc_clk) begin
    run_meta_q <= run;
    run_sync_q <= run_meta_q;
  end

  always_ff @(posedge osc_clk) begin
    if (run_sync_q) begin
      cnt_q <= cnt_q + {{(width-1){1'b0}}, 1'b1};
    end
  end

  assign count_q = cnt_q;
endmodule

// *** rtl/tile_status_config_regs.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - boot status bits 23:16 give processor number
// - boot bits 1:0 PLL pins, 3 RAM, 2 JTAG
// - boot bit 5 core off, 4 skip, 8 override
// - security bit 31 blocks further software security writes, but otp copy loads still replace the word
// - security 14 debug, 0 tap, 4 jtag cfg
// - bits 11:8 sector locks, 12 all, 7, 5
// - security register loaded from one-time memory copy
// - control bit1 core, bit0 periph oscillators, reset off
// - four 16-bit counters read in low bits
// - counters keep value through system reset
// - oscillators run asynchronous to the tile clock
// - ram size read in bits 31:2
// - debugger entry captures saved status word
// - captured status word keeps its documented bit fields
// - debugger entry captures saved program counter
// - debugger entry captures saved stack pointer
// - fetch core operand holds core number 7:0
// - fetch register operand holds register number 4:0
// - status read and write by register number
module tile_status_config_regs
  import tile_status_pkg::*;
#(
  parameter logic [31:0] ram_bytes = tile_status_pkg::ram_size_default
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ps_wr,
  input wire logic ps_rd,
  input wire logic [tile_status_pkg::reg_num_w-1:0] ps_reg,
  input wire logic [tile_status_pkg::data_w-1:0] ps_wdata,
  output logic [tile_status_pkg::data_w-1:0] ps_rdata,
  output logic ps_rvalid,
  input wire logic [7:0] processor_number,
  input wire logic [1:0] boot_pll_mode,
  input wire logic boot_from_ram,
  input wire logic boot_from_jtag,
  input wire logic second_core_off,
  input wire logic skip_otp_poll,
  input wire logic otp_sec_valid,
  input wire logic [tile_status_pkg::data_w-1:0] otp_sec_word,
  input wire logic [3:0] osc_clk,
  input wire logic debug_entry,
  input wire logic [tile_status_pkg::dbg_status_w-1:0] saved_status_word,
  input wire logic [tile_status_pkg::data_w-1:0] saved_program_counter,
  input wire logic [tile_status_pkg::data_w-1:0] saved_stack_pointer,
  output logic global_debug_off,
  output logic jtag_tap_off,
  output logic jtag_cfg_off,
  output logic [3:0] otp_sector_lock,
  output logic otp_redundancy_en,
  output logic boot_from_otp,
  output logic core_osc_en,
  output logic periph_osc_en,
  output logic [tile_status_pkg::fetch_core_w-1:0] debug_register_fetch_core,
  output logic [tile_status_pkg::fetch_reg_w-1:0] debug_register_fetch_reg
);
  import tile_status_pkg::*;

  logic [data_w-1:0] security_q;
  logic [1:0] osc_ctrl_q;
  logic [dbg_status_w-1:0] dbg_status_q;
  logic [data_w-1:0] dbg_pc_q;
  logic [data_w-1:0] dbg_sp_q;
  logic [fetch_core_w-1:0] fetch_core_q;
  logic [fetch_reg_w-1:0] fetch_reg_q;
  logic [data_w-1:0] rdata_d;
  logic [data_w-1:0] rdata_q;
  logic rvalid_q;
  logic [osc_cnt_w-1:0] osc_cnt [osc_count];
  logic [osc_cnt_w-1:0] cnt_hold_q [osc_count];
  logic [data_w-1:0] boot_word;
  logic [osc_count-1:0] osc_run;
  logic [otp_sectors-1:0] sector_lock_d;

  // boot status assembled from straps, with bit 8 taken from the security boot override bit
  always_comb begin
    boot_word = '0;
    boot_word[boot_proc_lsb +: 8] = processor_number;
    boot_word[boot_pll_lsb +: 2] = boot_pll_mode;
    boot_word[boot_from_ram_bit] = boot_from_ram;
    boot_word[boot_from_jtag_bit] = boot_from_jtag;
    boot_word[boot_core_off_bit] = second_core_off;
    boot_word[boot_skip_poll_bit] = skip_otp_poll;
    boot_word[boot_override_bit] = security_q[sec_boot_override_bit];
  end

  // one write strobe per writable register
  logic wr_security;
  logic wr_osc_ctrl;
  logic wr_dbg_status;
  logic wr_dbg_pc;
  logic wr_dbg_sp;
  logic wr_fetch_core;
  logic wr_fetch_reg;
  logic sec_locked;

  assign wr_security = ps_wr && (ps_reg == reg_security);
  assign wr_osc_ctrl = ps_wr && (ps_reg == reg_osc_control);
  assign wr_dbg_status = ps_wr && (ps_reg == reg_dbg_status);
  assign wr_dbg_pc = ps_wr && (ps_reg == reg_dbg_pc);
  assign wr_dbg_sp = ps_wr && (ps_reg == reg_dbg_sp);
  assign wr_fetch_core = ps_wr && (ps_reg == reg_fetch_core);
  assign wr_fetch_reg = ps_wr && (ps_reg == reg_fetch_reg);
  assign sec_locked = security_q[sec_write_lock_bit];

  // security word: otp copy load, then software writes until locked
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      security_q <= '0;
    end else if (otp_sec_valid) begin
      security_q <= otp_sec_word & sec_writable_mask;
    end else if (wr_security && !sec_locked) begin
      security_q <= ps_wdata & sec_writable_mask;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osc_ctrl_q <= osc_ctrl_reset;
    end else if (wr_osc_ctrl) begin
      osc_ctrl_q <= ps_wdata[osc_core_en_bit:osc_periph_en_bit];
    end
  end

  // debugger entry capture wins over a software write in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dbg_status_q <= '0;
    end else if (debug_entry) begin
      // reserved bit 5 is dropped on capture
      dbg_status_q <= saved_status_word & dbg_status_cmask;
    end else if (wr_dbg_status) begin
      // bit 8 is the live issue mode and cannot be written
      dbg_status_q <= (ps_wdata[dbg_status_w-1:0] & dbg_status_wmask)
        | (dbg_status_q & ~dbg_status_wmask);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dbg_pc_q <= '0;
    end else if (debug_entry) begin
      dbg_pc_q <= saved_program_counter;
    end else if (wr_dbg_pc) begin
      dbg_pc_q <= ps_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dbg_sp_q <= '0;
    end else if (debug_entry) begin
      dbg_sp_q <= saved_stack_pointer;
    end else if (wr_dbg_sp) begin
      dbg_sp_q <= ps_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fetch_core_q <= '0;
    end else if (wr_fetch_core) begin
      fetch_core_q <= ps_wdata[fetch_core_w-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fetch_reg_q <= '0;
    end else if (wr_fetch_reg) begin
      fetch_reg_q <= ps_wdata[fetch_reg_w-1:0];
    end
  end

  // cell/wire pairs: tile pair on core enable, periph pair on periph enable
  assign osc_run = {osc_ctrl_q[osc_periph_en_bit], osc_ctrl_q[osc_periph_en_bit],
    osc_ctrl_q[osc_core_en_bit], osc_ctrl_q[osc_core_en_bit]};

  genvar gi;
  generate
    for (gi = 0; gi < osc_count; gi++) begin : g_osc
      ring_osc_counter #(
        .width(osc_cnt_w)
      ) u_cnt (
        .osc_clk(osc_clk[gi]),
        .run(osc_run[gi]),
        .count_q(osc_cnt[gi])
      );
      // hold copy follows the count only once the stopped oscillator has settled,
      // so a word still changing in the oscillator domain is never taken
      logic [osc_settle_w-1:0] settle_q;
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          settle_q <= '0;
        end else if (osc_run[gi]) begin
          settle_q <= '0;
        end else if (settle_q != osc_settle_cycles) begin
          settle_q <= settle_q + 1'b1;
        end
      end
      // no reset here, the held count survives system reset
      always_ff @(posedge core_clk) begin
        if (!osc_run[gi] && settle_q == osc_settle_cycles) begin
          cnt_hold_q[gi] <= osc_cnt[gi];
        end
      end
    end
  endgenerate

  // read mux by register number
  always_comb begin
    rdata_d = '0;
    case (ps_reg)
      reg_boot_status: rdata_d = boot_word;
      reg_security: rdata_d = security_q;
      reg_osc_control: rdata_d[1:0] = osc_ctrl_q;
      reg_tile_cell_cnt: rdata_d[osc_cnt_w-1:0] = cnt_hold_q[0];
      reg_tile_wire_cnt: rdata_d[osc_cnt_w-1:0] = cnt_hold_q[1];
      reg_periph_cell_cnt: rdata_d[osc_cnt_w-1:0] = cnt_hold_q[2];
      reg_periph_wire_cnt: rdata_d[osc_cnt_w-1:0] = cnt_hold_q[3];
      reg_ram_size: rdata_d[data_w-1:ram_size_lsb] = ram_bytes[data_w-1:ram_size_lsb];
      reg_dbg_status: rdata_d[dbg_status_w-1:0] = dbg_status_q;
      reg_dbg_pc: rdata_d = dbg_pc_q;
      reg_dbg_sp: rdata_d = dbg_sp_q;
      reg_fetch_core: rdata_d[fetch_core_w-1:0] = fetch_core_q;
      reg_fetch_reg: rdata_d[fetch_reg_w-1:0] = fetch_reg_q;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= ps_rd;
    end
  end

  // read data holds until the next read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (ps_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign sector_lock_d = security_q[sec_lock_all_bit] ? {otp_sectors{1'b1}}
    : security_q[sec_sector_lock_lsb +: otp_sectors];

  // decoded controls registered so outputs come from flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      global_debug_off <= 1'b0;
      jtag_tap_off <= 1'b0;
      jtag_cfg_off <= 1'b0;
    end else begin
      global_debug_off <= security_q[sec_global_dbg_off_bit];
      jtag_tap_off <= security_q[sec_jtag_tap_off_bit];
      jtag_cfg_off <= security_q[sec_jtag_cfg_off_bit];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      otp_sector_lock <= '0;
      otp_redundancy_en <= 1'b0;
      boot_from_otp <= 1'b0;
    end else begin
      otp_sector_lock <= sector_lock_d;
      otp_redundancy_en <= security_q[sec_redundancy_bit];
      boot_from_otp <= security_q[sec_boot_override_bit];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      core_osc_en <= 1'b0;
      periph_osc_en <= 1'b0;
    end else begin
      core_osc_en <= osc_ctrl_q[osc_core_en_bit];
      periph_osc_en <= osc_ctrl_q[osc_periph_en_bit];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      debug_register_fetch_core <= '0;
      debug_register_fetch_reg <= '0;
    end else begin
      debug_register_fetch_core <= fetch_core_q;
      debug_register_fetch_reg <= fetch_reg_q;
    end
  end

  assign ps_rdata = rdata_q;
  assign ps_rvalid = rvalid_q;
endmodule

// *** sim/tile_status_config_regs_sva.sv ***
`timescale 1ns/100ps
module tile_status_config_regs_sva
  import tile_status_pkg::*;
#(
  parameter logic [31:0] ram_bytes = tile_status_pkg::ram_size_default
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ps_wr,
  input wire logic ps_rd,
  input wire logic [tile_status_pkg::reg_num_w-1:0] ps_reg,
  input wire logic [tile_status_pkg::data_w-1:0] ps_wdata,
  input wire logic [tile_status_pkg::data_w-1:0] ps_rdata,
  input wire logic ps_rvalid,
  input wire logic [7:0] processor_number,
  input wire logic [1:0] boot_pll_mode,
  input wire logic boot_from_ram,
  input wire logic boot_from_jtag,
  input wire logic second_core_off,
  input wire logic skip_otp_poll,
  input wire logic otp_sec_valid,
  input wire logic [tile_status_pkg::data_w-1:0] otp_sec_word,
  input wire logic debug_entry,
  input wire logic [tile_status_pkg::data_w-1:0] saved_program_counter,
  input wire logic global_debug_off,
  input wire logic [3:0] otp_sector_lock,
  input wire logic core_osc_en,
  input wire logic periph_osc_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence osc_wr;
    ps_wr && ps_reg == reg_osc_control;
  endsequence
  sequence capture_then_pc_read;
    debug_entry ##1 (ps_rd && !ps_wr && ps_reg == reg_dbg_pc);
  endsequence
  chk_read_answer: assert property (ps_rd |=> ps_rvalid)
    else $error("read not answered next cycle");
  chk_no_stray_valid: assert property (ps_rvalid |-> $past(ps_rd))
    else $error("read valid without a read");
  chk_osc_enables: assert property (osc_wr |-> ##2
    {core_osc_en, periph_osc_en} == $past(ps_wdata[1:0], 2)) else $error("osc enable wrong");
  chk_ram_size_read: assert property (ps_rd && ps_reg == reg_ram_size |=>
    ps_rdata == {ram_bytes[31:2], 2'h0}) else $error("ram size wrong");
  chk_boot_fields: assert property (ps_rd && ps_reg == reg_boot_status |=>
    ps_rdata[23:16] == $past(processor_number) && ps_rdata[5:0] == $past({second_core_off,
    skip_otp_poll, boot_from_ram, boot_from_jtag, boot_pll_mode})) else $error("boot bad");
  chk_otp_load: assert property (otp_sec_valid |-> ##2
    otp_sector_lock == ($past(otp_sec_word[12], 2) ? 4'hf : $past(otp_sec_word[11:8], 2))
    && global_debug_off == $past(otp_sec_word[14], 2)) else $error("otp load wrong");
  chk_pc_capture: assert property (capture_then_pc_read |=>
    ps_rdata == $past(saved_program_counter, 2)) else $error("pc capture wrong");
  chk_unmapped_zero: assert property (ps_rd && ps_reg inside {8'h04, 8'h0b} |=>
    ps_rdata == 32'h0) else $error("unmapped read not zero");
endmodule
bind tile_status_config_regs tile_status_config_regs_sva #(.ram_bytes(ram_bytes)) chk (.*);

// *** sim/tile_status_config_regs_tb_top.sv ***
`timescale 1ns/100ps
module tile_status_config_regs_tb_top;
  import tile_status_pkg::*;
  logic core_clk = 0, nrst = 0, ps_wr = 0, ps_rd = 0, otp_sec_valid = 0, debug_entry = 0;
  logic boot_from_ram = 1, boot_from_jtag = 0, second_core_off = 1, skip_otp_poll = 0;
  logic [7:0] ps_reg = 0, processor_number = 8'ha5;
  logic [1:0] boot_pll_mode = 2'h2;
  logic [31:0] ps_wdata = 0, otp_sec_word = 0, saved_program_counter = 0;
  logic [31:0] saved_stack_pointer = 0, ps_rdata, d;
  logic [31:0] cnt [4];
  logic [3:0] osc_clk = 4'h5, otp_sector_lock;
  logic [10:0] saved_status_word = 0;
  logic ps_rvalid, global_debug_off, jtag_tap_off, jtag_cfg_off, otp_redundancy_en;
  logic boot_from_otp, core_osc_en, periph_osc_en;
  logic [7:0] debug_register_fetch_core;
  logic [4:0] debug_register_fetch_reg;
  int errors = 0, num_checks = 0;
  logic [95:0] rows [10] = '{
    {24'h0, reg_osc_control, 32'hffff_ffff, 32'h3}, {24'h0, reg_fetch_core, 32'hffff_ffff, 32'hff},
    {24'h0, reg_fetch_reg, 32'hffff_ffff, 32'h1f}, {24'h0, reg_dbg_status, 32'hffff_ffff, 32'h6df},
    {24'h0, reg_dbg_pc, 32'h1234_5678, 32'h1234_5678}, {24'h0, reg_dbg_sp, 32'h9abc_def0,
    32'h9abc_def0}, {24'h0, reg_ram_size, 32'h0, 32'h0001_0000}, {32'h04, 32'hffff_ffff, 32'h0},
    {32'h0b, 32'hffff_ffff, 32'h0}, {24'h0, reg_security, 32'h7fff_ffdf, 32'h0000_5f91}};
  tile_status_config_regs #(.ram_bytes(32'h0001_0003)) dut (.*);
  initial forever #5 core_clk = ~core_clk;
  always #3.3 osc_clk = ~osc_clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] r, input logic [31:0] v);
    @(posedge core_clk) #1;
    ps_wr = 1;
    ps_reg = r;
    ps_wdata = v;
    @(posedge core_clk) #1;
    ps_wr = 0;
  endtask
  task automatic rd(input logic [7:0] r, output logic [31:0] v, input bit now = 0);
    if (!now) @(posedge core_clk) #1;
    ps_rd = 1;
    ps_reg = r;
    @(posedge core_clk) #1;
    ps_rd = 0;
    check(32'(ps_rvalid), 32'h1);
    v = ps_rdata;
  endtask
  task automatic otp(input logic [31:0] w);
    @(posedge core_clk) #1;
    otp_sec_word = w;
    otp_sec_valid = 1;
    @(posedge core_clk) #1;
    otp_sec_valid = 0;
    @(posedge core_clk) #1;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    #1 nrst = 1;
    rd(reg_boot_status, d);
    check(d, 32'h00a5_002a);
    for (int i = 0; i < 10; i++) begin
      wr(rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64], d);
      check(d, rows[i][31:0]);
    end
    check(32'({core_osc_en, periph_osc_en, global_debug_off, jtag_tap_off, jtag_cfg_off,
      otp_sector_lock, otp_redundancy_en, boot_from_otp}), 32'h7fe);
    check(32'({debug_register_fetch_core, debug_register_fetch_reg}), 32'h1fff);
    $display("test rows done");
    @(posedge core_clk) #1;
    saved_status_word = 11'h7ff;
    saved_program_counter = 32'hdead_0001;
    saved_stack_pointer = 32'h0000_beef;
    debug_entry = 1;
    ps_wr = 1;
    ps_reg = reg_dbg_pc;
    ps_wdata = 32'h1;
    @(posedge core_clk) #1;
    debug_entry = 0;
    ps_wr = 0;
    rd(reg_dbg_pc, d, 1);
    check(d, 32'hdead_0001);
    rd(reg_dbg_sp, d);
    check(d, 32'h0000_beef);
    rd(reg_dbg_status, d);
    check(d, 32'h7df);
    $display("test capture done");
    wr(reg_security, 32'h8000_0001);
    wr(reg_security, 32'h0000_4000);
    rd(reg_security, d);
    check(d, 32'h8000_0001);
    check(32'({global_debug_off, jtag_tap_off}), 32'h1);
    otp(32'hffff_ffff);
    rd(reg_security, d);
    check(d, 32'h8000_5fb1);
    check(32'(otp_sector_lock), 32'hf);
    $display("test lock done");
    wr(reg_osc_control, 32'h0);
    repeat (20) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      rd(8'(reg_tile_cell_cnt + i), cnt[i]);
      check(32'(cnt[i][31:16]), 32'h0);
      check(32'(cnt[i] != 32'h0), 32'h1);
    end
    nrst = 0;
    repeat (16) @(posedge core_clk);
    #1 nrst = 1;
    for (int i = 0; i < 4; i++) begin
      rd(8'(reg_tile_cell_cnt + i), d);
      check(d, cnt[i]);
    end
    rd(reg_osc_control, d);
    check(d, 32'h0);
    otp(32'h0000_0580);
    check(32'({otp_sector_lock, otp_redundancy_en}), 32'h0b);
    $display("test reset done");
    report_and_stop();
  end
endmodule
